//--- hw/dists_defines.svh
// offsets, field positions and timing counts for the id and event status block
`ifndef DISTS_DEFINES_SVH
`define DISTS_DEFINES_SVH
`define DISTS_OFS_CHIP_IDENTITY_REVISION 12'h000
`define DISTS_OFS_STATUS 12'h008
`define DISTS_OFS_CTRL 12'h00C
`define DISTS_BIT_MACRTO 18
`define DISTS_BIT_TXSTOP 17
`define DISTS_BIT_RXSTOP 16
`define DISTS_BIT_PHY 15
`define DISTS_BIT_TXE 14
`define DISTS_BIT_TX_FIFO_UNDERRUN_FLAG 13
`define DISTS_BIT_TX_FIFO_OVERRUN_FLAG 12
`define DISTS_BIT_RXDF 11
`define DISTS_PIN_COUNT 11
`define DISTS_MAC_TIMEOUT_MS 8
`define DISTS_CLK_MHZ 100
`define DISTS_MAC_TIMEOUT_CYC (`DISTS_MAC_TIMEOUT_MS * 1000 * `DISTS_CLK_MHZ)
`define DISTS_CTRL_STOP_BIT 1
`define DISTS_CTRL_EXTPHY_BIT 0
`endif

//--- hw/dists_pkg.sv
// types for the id and event status block
package dists_pkg;
    typedef struct packed {
        logic tx_halted;
        logic rx_halted;
        logic tx_error;
        logic tx_underrun;
        logic tx_overrun;
        logic rx_dropped;
    } dists_events_t;
    typedef enum logic [1:0] {
        DISTS_TX_RUN = 2'h0,
        DISTS_TX_DRAIN = 2'h1,
        DISTS_TX_HALT = 2'h3
    } dists_tx_state_t;
endpackage

//--- hw/dists_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dists_sync
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else if (ce)
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            dout <= 1'b0;
        else if (ce && (s2_r == s3_r))
            dout <= s3_r;
    end
endmodule

//--- hw/dists_top.sv
// device id register, event status register and mac reset supervision
//
// Function
// (R1) id register: model code high half, revision low half, read-only
// (R2) set bit 18 when eight millisecond mac reset timer expires
// (R3) after timeout release mac reset without waiting for phy clocks
// (R4) set bit 17 when stop requested and transmitter halted
// (R5) set bit 16 whenever receiver halts
// (R6) bit 15 read-only, follows phy interrupt level, not write-clearable
// (R7) bit 15 selects internal or external phy interrupt by configuration
// (R8) set bit 14 on transmit error
// (R9) set bit 13 on transmit fifo underrun
// (R10) set bit 12 on transmit fifo overrun
// (R11) set bit 11 whenever a received frame is dropped
// (R12) pulse events latch; write one clears, write zero leaves
// (R13) bits 10..0 flag the eleven pin interrupt levels
// (R14) after reset pin flags take the current pin state
// (R15) clearing a pin flag also clears that pin wake event
// (R16) stop finishes current frame, then stop request self-clears
// (R17) bits 31..19 read zero and ignore writes
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "dists_defines.svh"
module dists_top
#(
    parameter logic [15:0] MODEL_CODE = 16'h0A5A, // arbitrary value
    parameter logic [15:0] REVISION = 16'h0001, // arbitrary value
    parameter int MAC_TIMEOUT_CYC = `DISTS_MAC_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire dists_pkg::dists_events_t events,
    input wire logic tx_frame_busy,
    output logic tx_stop_req,
    input wire logic int_phy_irq,
    input wire logic ext_phy_irq,
    input wire logic [10:0] pin_irq,
    output logic [10:0] wake_clear,
    input wire logic mac_reset_req,
    input wire logic phy_clk_seen,
    output logic mac_reset
);
    logic [10:0] pin_s;
    logic int_phy_s;
    logic ext_phy_s;
    logic ext_phy_sel_r;
    logic [7:0] pulse_flags_r;
    logic [10:0] pin_flags_r;
    logic pin_loaded_r;
    logic [31:0] status;
    logic phy_level;
    logic [31:0] cnt_r;
    logic timeout_pulse;
    logic wr_status;
    logic wr_ctrl;
    logic [31:0] clr_mask;
    dists_pkg::dists_tx_state_t tx_state_r;
    dists_pkg::dists_tx_state_t tx_state_nxt;
    logic tx_halt_pulse;

    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < `DISTS_PIN_COUNT; gi++)
        begin : g_pin
            dists_sync u_sync
            (
                .clk(clk),
                .resetn(resetn),
                .ce(ce),
                .din(pin_irq[gi]),
                .dout(pin_s[gi])
            );
        end
    endgenerate
    dists_sync u_int_phy
    (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .din(int_phy_irq),
        .dout(int_phy_s)
    );
    dists_sync u_ext_phy
    (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .din(ext_phy_irq),
        .dout(ext_phy_s)
    );

    ////////////////////////////////////////////////////////////////////////
    assign wr_status = wr && (addr == `DISTS_OFS_STATUS);
    assign wr_ctrl = wr && (addr == `DISTS_OFS_CTRL);
    assign clr_mask = wr_status ? wdata : 32'h0000_0000;
    assign phy_level = ext_phy_sel_r ? ext_phy_s : int_phy_s; // R7

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ext_phy_sel_r <= 1'b0;
        else if (ce && wr_ctrl)
            ext_phy_sel_r <= wdata[`DISTS_CTRL_EXTPHY_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // mac reset supervision: count while reset held and no phy clock seen
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt_r <= 32'h0000_0000;
        else if (ce)
        begin
            if (!mac_reset_req || phy_clk_seen)
                cnt_r <= 32'h0000_0000;
            else if (cnt_r < 32'(MAC_TIMEOUT_CYC))
                cnt_r <= cnt_r + 32'h0000_0001;
        end
    end
    assign timeout_pulse = ce && mac_reset_req && !phy_clk_seen && (cnt_r == 32'(MAC_TIMEOUT_CYC - 1)); // R2
    // release without the phy clocks once timer expires
    assign mac_reset = mac_reset_req && !phy_clk_seen && (cnt_r < 32'(MAC_TIMEOUT_CYC)); // R3

    ////////////////////////////////////////////////////////////////////////
    // transmitter stop sequencing
    always_comb
    begin
        tx_state_nxt = tx_state_r;
        case (tx_state_r)
            dists_pkg::DISTS_TX_RUN:
                if (wr_ctrl && wdata[`DISTS_CTRL_STOP_BIT])
                    tx_state_nxt = dists_pkg::DISTS_TX_DRAIN;
            dists_pkg::DISTS_TX_DRAIN:
                if (!tx_frame_busy)
                    tx_state_nxt = dists_pkg::DISTS_TX_HALT; // R16
            dists_pkg::DISTS_TX_HALT:
                tx_state_nxt = dists_pkg::DISTS_TX_RUN;
            default:
                tx_state_nxt = dists_pkg::DISTS_TX_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tx_state_r <= dists_pkg::DISTS_TX_RUN;
        else if (ce)
            tx_state_r <= tx_state_nxt;
    end
    assign tx_stop_req = (tx_state_r == dists_pkg::DISTS_TX_DRAIN); // R16
    assign tx_halt_pulse = ce && (tx_state_r == dists_pkg::DISTS_TX_DRAIN) && !tx_frame_busy; // R4

    ////////////////////////////////////////////////////////////////////////
    // sticky pulse flags, set wins over clear; index = bit - 11
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pulse_flags_r <= 8'h00;
        else if (ce)
        begin
            pulse_flags_r <= (pulse_flags_r & ~clr_mask[18:11]) | { // R12
                timeout_pulse, // R2
                tx_halt_pulse | events.tx_halted, // R4
                events.rx_halted, // R5
                1'b0,
                events.tx_error, // R8
                events.tx_underrun, // R9
                events.tx_overrun, // R10
                events.rx_dropped}; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin flags latch levels until written one; first load after reset takes pin state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_flags_r <= 11'h000;
            pin_loaded_r <= 1'b0;
        end
        else if (ce)
        begin
            pin_loaded_r <= 1'b1;
            if (!pin_loaded_r)
                pin_flags_r <= pin_s; // R14
            else
                pin_flags_r <= (pin_flags_r & ~clr_mask[10:0]) | pin_s; // R13
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wake_clear <= 11'h000;
        else if (ce)
            wake_clear <= clr_mask[10:0] & pin_flags_r; // R15
    end

    ////////////////////////////////////////////////////////////////////////
    assign status = {13'h0000, pulse_flags_r[7:5], phy_level, pulse_flags_r[3:0], pin_flags_r}; // R6 R17

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= 32'h0000_0000;
        else if (ce)
        begin
            if (rd)
            begin
                case (addr)
                    `DISTS_OFS_CHIP_IDENTITY_REVISION: rdata <= {MODEL_CODE, REVISION}; // R1
                    `DISTS_OFS_STATUS: rdata <= status;
                    `DISTS_OFS_CTRL: rdata <= {30'h0000_0000, tx_stop_req, ext_phy_sel_r};
                    default: rdata <= 32'h0000_0000;
                endcase
            end
            else
                rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    timeout_sets_a: assert property (@(posedge clk) disable iff (!resetn)
        timeout_pulse |=> pulse_flags_r[7]) else $error("timeout flag not set"); // R2
    release_after_a: assert property (@(posedge clk) disable iff (!resetn)
        (cnt_r >= 32'(MAC_TIMEOUT_CYC)) |-> !mac_reset) else $error("mac reset held past timeout"); // R3
    halt_sets_a: assert property (@(posedge clk) disable iff (!resetn)
        tx_halt_pulse |=> pulse_flags_r[6]) else $error("tx halted flag not set"); // R4
    phy_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        status[15] == phy_level) else $error("phy flag not following level"); // R6
    sticky_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (ce && pulse_flags_r[0] && !clr_mask[11]) |=> pulse_flags_r[0]) else $error("drop flag lost"); // R12
    w1c_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (ce && clr_mask[13] && !events.tx_underrun) |=> !pulse_flags_r[2]) else $error("underrun not cleared"); // R12
    wake_clr_a: assert property (@(posedge clk) disable iff (!resetn)
        (ce && wr_status && wdata[0] && pin_flags_r[0]) |=> wake_clear[0]) else $error("wake not cleared"); // R15
    stop_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (ce && tx_stop_req && !tx_frame_busy) |=> ##1 !tx_stop_req) else $error("stop not self clearing"); // R16
    reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        status[31:19] == 13'h0000) else $error("reserved bits nonzero"); // R17
endmodule

//--- test/dists_tb_top.sv
// self-checking bench for the id and event status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dists_tb_top;
    localparam logic [15:0] MODEL = 16'h0A5A; // arbitrary value
    localparam logic [15:0] REV = 16'h0001; // arbitrary value
    typedef struct packed {logic [5:0] ev; logic [31:0] st;} dists_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    dists_pkg::dists_events_t events = '0;
    logic tx_frame_busy = 1'b0;
    logic tx_stop_req;
    logic int_phy_irq = 1'b0;
    logic ext_phy_irq = 1'b0;
    logic [10:0] pin_irq = 11'h000;
    logic [10:0] wake_clear;
    logic mac_reset_req = 1'b0;
    logic mac_reset;
    logic ce = 1'b1;
    logic phy_clk_seen = 1'b0;
    logic [31:0] d;
    logic [10:0] wk = 11'h000;
    int err_total = 0;
    int tests_run = 0;
    int n;
    // one pulse source per row
    dists_row_t rows [6] = '{'{6'h20, 32'h00020000}, '{6'h10, 32'h00010000}, '{6'h08, 32'h00004000},
        '{6'h04, 32'h00002000}, '{6'h02, 32'h00001000}, '{6'h01, 32'h00000800}};

    always #5 clk = ~clk;
    always @(posedge clk) wk <= wk | wake_clear;

    dists_top #(.MODEL_CODE(MODEL), .REVISION(REV), .MAC_TIMEOUT_CYC(20)) dut_u
    (
        .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .events(events), .tx_frame_busy(tx_frame_busy), .tx_stop_req(tx_stop_req),
        .int_phy_irq(int_phy_irq), .ext_phy_irq(ext_phy_irq), .pin_irq(pin_irq),
        .wake_clear(wake_clear), .mac_reset_req(mac_reset_req), .phy_clk_seen(phy_clk_seen),
        .mac_reset(mac_reset)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic chk_st(input string nm, input logic [31:0] e);
        logic [31:0] v;
        rd_reg(12'h008, v);
        `CHK(nm, e, v)
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial
    begin
        idle(3);
        resetn <= 1'b1;
        idle(8);
        rd_reg(12'h000, d);
        `CHK("id", {MODEL, REV}, d)
        wr_reg(12'h000, 32'hFFFFFFFF);
        rd_reg(12'h000, d);
        `CHK("id_ro", {MODEL, REV}, d)
        rd_reg(12'h004, d);
        `CHK("unmapped", 32'h0, d)
        wr_reg(12'h008, 32'hFFF88000);
        chk_st("reserved", 32'h0);
        $display("test id done");
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            events <= rows[i].ev;
            @(posedge clk);
            events <= '0;
            chk_st("latched", rows[i].st);
            wr_reg(12'h008, 32'h0);
            chk_st("kept", rows[i].st);
            wr_reg(12'h008, rows[i].st);
            chk_st("cleared", 32'h0);
        end
        $display("test events done");
        @(posedge clk);
        int_phy_irq <= 1'b1;
        idle(8);
        wr_reg(12'h008, 32'h00008000);
        chk_st("line_phy_event_flag", 32'h00008000);
        wr_reg(12'h00C, 32'h00000001);
        idle(8);
        chk_st("phy_ext_lo", 32'h0);
        @(posedge clk);
        ext_phy_irq <= 1'b1;
        int_phy_irq <= 1'b0;
        idle(8);
        chk_st("phy_ext_hi", 32'h00008000);
        @(posedge clk);
        ext_phy_irq <= 1'b0;
        idle(8);
        chk_st("phy_low", 32'h0);
        $display("test phy done");
        @(posedge clk);
        pin_irq <= 11'h401;
        idle(8);
        chk_st("pins", 32'h00000401);
        @(posedge clk);
        pin_irq <= 11'h000;
        idle(8);
        wr_reg(12'h008, 32'h00000001);
        idle(3);
        `CHK("wake", 11'h001, wk)
        chk_st("pin_kept", 32'h00000400);
        wr_reg(12'h008, 32'h00000400);
        chk_st("pins_clr", 32'h0);
        $display("test pins done");
        @(posedge clk);
        tx_frame_busy <= 1'b1;
        wr_reg(12'h00C, 32'h00000002);
        @(negedge clk);
        `CHK("stop_req", 1'b1, tx_stop_req)
        chk_st("draining", 32'h0);
        @(posedge clk);
        tx_frame_busy <= 1'b0;
        for (n = 0; n < 10 && tx_stop_req !== 1'b0; n++)
            @(negedge clk);
        `CHK("stop_clr", 1'b0, tx_stop_req)
        if (n == 10)
            summarize();
        chk_st("halted", 32'h00020000);
        wr_reg(12'h008, 32'h00020000);
        $display("test stop done");
        mac_reset_req <= 1'b1;
        idle(10);
        @(negedge clk);
        `CHK("mac_hold", 1'b1, mac_reset)
        for (n = 0; n < 40 && mac_reset !== 1'b0; n++)
            @(negedge clk);
        `CHK("mac_rel", 1'b0, mac_reset)
        if (n == 40)
            summarize();
        @(posedge clk);
        mac_reset_req <= 1'b0;
        chk_st("timeout", 32'h00040000);
        wr_reg(12'h008, 32'h00040000);
        chk_st("timeout_clr", 32'h0);
        $display("test timeout done");
        // phy clock present: supervision timer never expires
        @(posedge clk);
        phy_clk_seen <= 1'b1;
        mac_reset_req <= 1'b1;
        idle(30);
        @(negedge clk);
        `CHK("mac_clk_ok", 1'b0, mac_reset)
        @(posedge clk);
        mac_reset_req <= 1'b0;
        phy_clk_seen <= 1'b0;
        chk_st("no_timeout", 32'h0);
        $display("test phy clock done");
        // enable low: a pulse event must not latch
        @(posedge clk);
        ce <= 1'b0;
        events <= 6'h01;
        @(posedge clk);
        events <= '0;
        ce <= 1'b1;
        chk_st("frozen", 32'h0);
        $display("test enable done");
        @(posedge clk);
        pin_irq <= 11'h003;
        events <= 6'h01;
        @(posedge clk);
        events <= '0;
        resetn <= 1'b0;
        idle(3);
        resetn <= 1'b1;
        idle(8);
        chk_st("reset_pins", 32'h00000003);
        $display("test reset done");
        summarize();
    end
endmodule
